// ==== design/i2c_host_pkg.sv ====
// Constants for the two-wire bus host controller and its APB register map.
// How it works
// - Device software flips direction before reading data when leaving receive.
// - First byte after start is 7-bit address in bits 7..1, R/W in bit 0.
// - Start only with both lines high; start is SDA falling while SCL high.
// - Address byte carries direction bit: 1 slave sends, 0 master sends.
// - Device software never calls its own slave address as master.
// - Bytes are 8 bits MSB first; SDA changes only while SCL is low.
// - Receiver acknowledges on ninth clock; a byte takes nine SCL pulses.
// - No acknowledge from slave leaves SDA high; master records failure.
// - Master receiver not acknowledging ends data; slave releases SDA.
// - After an abort the master sends stop or a repeated start.
// - Stop is SDA rising while SCL high; allowed even after an acknowledge.
// - Repeated start without stop keeps the bus for a new address phase.
// - Each party times SCL low from the fall, waits for real rise, times high.
// - Lines are driven only open-drain into a wired-AND.
package i2c_host_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD  = 8'h00;
    localparam logic [7:0] ADDR_TXD  = 8'h04;
    localparam logic [7:0] ADDR_RXD  = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;

    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;
    localparam int CMD_WRITE = 2;
    localparam int CMD_READ  = 3;
    localparam int CMD_NACK  = 4;

    localparam int STAT_BUSY     = 0;
    localparam int STAT_BUS_BUSY = 1;
    localparam int STAT_RXAK     = 2;
    localparam int STAT_ARB_LOST = 3;
    localparam int STAT_DONE     = 4;

    localparam int         BYTE_W    = 8;
    localparam logic [3:0] LAST_BIT  = 4'h8;
    localparam logic [3:0] ACK_SLOT  = 4'h8;

    // ----------------------------------------------------------------
    // Bus timing
    // ----------------------------------------------------------------
    localparam int TW         = 8;
    localparam int CLK_NS     = 25;
    localparam int T_LOW_NS   = 4700;
    localparam int T_HIGH_NS  = 4000;
    localparam int T_SU_NS    = 4700;
    localparam int T_HD_NS    = 4000;
    localparam int T_BUF_NS   = 4700;
    localparam int T_HDAT_NS  = 300;

    localparam logic [TW-1:0] T_LOW_CYC  = TW'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_HIGH_CYC = TW'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_SU_CYC   = TW'((T_SU_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_HD_CYC   = TW'((T_HD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_BUF_CYC  = TW'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_HDAT_CYC = TW'((T_HDAT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TW-1:0] T_LREST_CYC = T_LOW_CYC - T_HDAT_CYC;

endpackage : i2c_host_pkg

// ==== design/i2c_sync.sv ====
// Two-flop synchronizer for the bus line inputs.
`timescale 1ns/1ps
module i2c_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Lines
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // Idle bus reads high, so both stages reset to ones
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : i2c_sync

// ==== design/i2c_phase_timer.sv ====
// Down counter that times one bus phase.
`timescale 1ns/1ps
module i2c_phase_timer (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // Control
    input  wire logic                       load,
    input  wire logic [i2c_host_pkg::TW-1:0] load_val,
    output logic                            expired
);

    logic [i2c_host_pkg::TW-1:0] cnt_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign expired = (cnt_q == '0);

endmodule : i2c_phase_timer

// ==== design/i2c_host.sv ====
// Two-wire bus master that addresses the device as a slave, driven over APB.
`timescale 1ns/1ps
module i2c_host (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus lines, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    // ----------------------------------------------------------------
    // Types and declarations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_IDLE, PH_S_REL, PH_S_SCLH, PH_S_SU, PH_S_HD,
        PH_B_HOLD, PH_B_LOW, PH_B_WAITH, PH_B_HIGH, PH_E_HOLD,
        PH_P_LOW, PH_P_WAITH, PH_P_SU, PH_P_BUF
    } phase_e;

    localparam int BYTE_W_L = i2c_host_pkg::BYTE_W;

    phase_e                  state_q;
    phase_e                  state_d;
    logic [1:0]              lines_s;
    logic                    scl_s;
    logic                    sda_s;
    logic                    sda_prev_q;
    logic                    start_seen;
    logic                    stop_seen;
    logic                    bus_busy_q;
    logic                    own_q;
    logic                    own_d;
    logic                    scl_oe_q;
    logic                    sda_oe_q;
    logic                    scl_oe_d;
    logic                    sda_oe_d;
    logic [BYTE_W_L:0]       shift_q;
    logic [3:0]              cnt_q;
    logic                    stop_q;
    logic                    rd_q;
    logic [7:0]              txd_q;
    logic [7:0]              rxd_q;
    logic                    rxak_q;
    logic                    arb_lost_q;
    logic                    done_q;
    logic [31:0]             prdata_q;
    logic                    exp;
    logic                    high_end;
    logic                    acc_wr;
    logic                    cmd_go;
    logic                    arb_bit;
    logic                    arb_start;
    logic                    arb_su;
    logic                    arb_stop;
    logic                    set_arb;
    logic                    set_done;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        if (a == i2c_host_pkg::ADDR_CMD) begin
            is_mapped = 1'b1;
        end else if (a == i2c_host_pkg::ADDR_TXD) begin
            is_mapped = 1'b1;
        end else if (a == i2c_host_pkg::ADDR_RXD) begin
            is_mapped = 1'b1;
        end else if (a == i2c_host_pkg::ADDR_STAT) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction : is_mapped

    // Time spent in each timed phase
    function automatic logic [i2c_host_pkg::TW-1:0] dwell(input phase_e st);
        case (st)
            PH_S_REL:  dwell = i2c_host_pkg::T_HDAT_CYC;
            PH_S_SU:   dwell = i2c_host_pkg::T_SU_CYC;
            PH_S_HD:   dwell = i2c_host_pkg::T_HD_CYC;
            PH_B_HOLD: dwell = i2c_host_pkg::T_HDAT_CYC;
            PH_B_LOW:  dwell = i2c_host_pkg::T_LREST_CYC;
            PH_B_HIGH: dwell = i2c_host_pkg::T_HIGH_CYC;
            PH_E_HOLD: dwell = i2c_host_pkg::T_HDAT_CYC;
            PH_P_LOW:  dwell = i2c_host_pkg::T_LOW_CYC;
            PH_P_SU:   dwell = i2c_host_pkg::T_SU_CYC;
            PH_P_BUF:  dwell = i2c_host_pkg::T_BUF_CYC;
            default:   dwell = '0;
        endcase
    endfunction : dwell

    // ----------------------------------------------------------------
    // Line sampling and start/stop watch
    // ----------------------------------------------------------------
    i2c_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({scl_in, sda_in}),
        .sync_out (lines_s)
    );

    assign scl_s      = lines_s[1];
    assign sda_s      = lines_s[0];
    assign start_seen = scl_s & sda_prev_q & ~sda_s;
    assign stop_seen  = scl_s & ~sda_prev_q & sda_s;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_prev_q <= 1'b1;
            bus_busy_q <= 1'b0;
        end else begin
            sda_prev_q <= sda_s;
            if (start_seen) begin
                bus_busy_q <= 1'b1;
            end else if (stop_seen) begin
                bus_busy_q <= 1'b0;
            end
        end
    end

    i2c_phase_timer u_timer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (state_d != state_q),
        .load_val (dwell(state_d)),
        .expired  (exp)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);
    assign prdata  = prdata_q;
    assign acc_wr  = psel & penable & pwrite;
    assign cmd_go  = acc_wr & (paddr == i2c_host_pkg::ADDR_CMD) & (state_q == PH_IDLE);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            if (paddr == i2c_host_pkg::ADDR_TXD) begin
                prdata_q <= {24'h0, txd_q};
            end else if (paddr == i2c_host_pkg::ADDR_RXD) begin
                // Reading received data has no side effect; only a command starts a byte
                prdata_q <= {24'h0, rxd_q};
            end else if (paddr == i2c_host_pkg::ADDR_STAT) begin
                prdata_q <= {27'h0, done_q, arb_lost_q, rxak_q, bus_busy_q,
                             (state_q != PH_IDLE)};
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txd_q <= 8'h0;
        end else if (acc_wr & (paddr == i2c_host_pkg::ADDR_TXD)) begin
            txd_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Arbitration watch
    // ----------------------------------------------------------------
    // Another device pulling SCL early cuts our high phase short
    assign high_end  = exp | ~scl_s;
    assign arb_bit   = (state_q == PH_B_HIGH) & high_end & shift_q[BYTE_W_L] & ~sda_s
                     & (rd_q ? (cnt_q == i2c_host_pkg::ACK_SLOT)
                             : (cnt_q < i2c_host_pkg::ACK_SLOT));
    assign arb_start = cmd_go & pwdata[i2c_host_pkg::CMD_START] & bus_busy_q & ~own_q;
    assign arb_su    = (state_q == PH_S_SU) & exp & ~sda_s;
    assign arb_stop  = stop_seen & own_q & (state_q != PH_P_SU) & (state_q != PH_P_BUF);
    assign set_arb   = arb_bit | arb_start | arb_su | arb_stop;
    assign set_done  = (state_q != PH_IDLE) & (state_d == PH_IDLE);

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        own_d   = own_q;
        case (state_q)
            PH_IDLE: begin
                if (cmd_go) begin
                    if (pwdata[i2c_host_pkg::CMD_START]) begin
                        state_d = arb_start ? PH_IDLE : PH_S_REL;
                    end else if (own_q & (pwdata[i2c_host_pkg::CMD_WRITE]
                                          | pwdata[i2c_host_pkg::CMD_READ])) begin
                        state_d = PH_B_HOLD;
                    end else if (own_q & pwdata[i2c_host_pkg::CMD_STOP]) begin
                        state_d = PH_P_LOW;
                    end
                end
            end
            PH_S_REL:   if (exp) state_d = PH_S_SCLH;
            PH_S_SCLH:  if (scl_s) state_d = PH_S_SU;
            PH_S_SU:    if (exp) state_d = arb_su ? PH_IDLE : PH_S_HD;
            PH_S_HD: begin
                if (exp) begin
                    own_d = 1'b1;
                    if (cnt_q != '1) begin
                        state_d = PH_B_HOLD;
                    end else begin
                        state_d = stop_q ? PH_P_LOW : PH_IDLE;
                    end
                end
            end
            PH_B_HOLD:  if (exp) state_d = PH_B_LOW;
            PH_B_LOW:   if (exp) state_d = PH_B_WAITH;
            PH_B_WAITH: if (scl_s) state_d = PH_B_HIGH;
            PH_B_HIGH: begin
                if (high_end) begin
                    if (arb_bit) begin
                        state_d = PH_IDLE;
                    end else if (cnt_q == i2c_host_pkg::LAST_BIT) begin
                        state_d = PH_E_HOLD;
                    end else begin
                        state_d = PH_B_HOLD;
                    end
                end
            end
            PH_E_HOLD:  if (exp) state_d = stop_q ? PH_P_LOW : PH_IDLE;
            PH_P_LOW:   if (exp) state_d = PH_P_WAITH;
            PH_P_WAITH: if (scl_s) state_d = PH_P_SU;
            PH_P_SU:    if (exp) state_d = PH_P_BUF;
            PH_P_BUF: begin
                if (exp) begin
                    state_d = PH_IDLE;
                    own_d   = 1'b0;
                end
            end
            default:    state_d = PH_IDLE;
        endcase
        // Losing leaves the bus at once with no stop of our own
        if (set_arb) begin
            state_d = PH_IDLE;
            own_d   = 1'b0;
        end
    end

    // Line drive follows the phase being entered
    always_comb begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        case (state_d)
            PH_IDLE:    scl_oe_d = own_d;
            PH_S_REL:   scl_oe_d = own_q;
            PH_S_HD:    sda_oe_d = 1'b1;
            PH_B_HOLD: begin
                scl_oe_d = 1'b1;
                sda_oe_d = sda_oe_q;
            end
            PH_B_LOW: begin
                scl_oe_d = 1'b1;
                sda_oe_d = ~shift_q[BYTE_W_L];
            end
            PH_B_WAITH, PH_B_HIGH: sda_oe_d = ~shift_q[BYTE_W_L];
            PH_E_HOLD: begin
                scl_oe_d = 1'b1;
                sda_oe_d = sda_oe_q;
            end
            PH_P_LOW: begin
                scl_oe_d = 1'b1;
                sda_oe_d = 1'b1;
            end
            PH_P_WAITH, PH_P_SU: sda_oe_d = 1'b1;
            default: begin
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= PH_IDLE;
            own_q    <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            own_q    <= own_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // Drivers only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_oe_q;
    assign sda_oe  = sda_oe_q;

    // ----------------------------------------------------------------
    // Byte shifter
    // ----------------------------------------------------------------
    // Bit 8 is the bit on the wire; the ack slot is released on write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '1;
            cnt_q   <= '1;
            stop_q  <= 1'b0;
            rd_q    <= 1'b0;
            rxd_q   <= 8'h0;
            rxak_q  <= 1'b1;
        end else if (cmd_go) begin
            stop_q <= pwdata[i2c_host_pkg::CMD_STOP];
            rd_q   <= pwdata[i2c_host_pkg::CMD_READ];
            if (pwdata[i2c_host_pkg::CMD_READ]) begin
                shift_q <= {8'hFF, pwdata[i2c_host_pkg::CMD_NACK]};
                cnt_q   <= '0;
            end else if (pwdata[i2c_host_pkg::CMD_WRITE]) begin
                // The host has no slave address of its own, so no call can name it
                shift_q <= {txd_q, 1'b1};
                cnt_q   <= '0;
            end else begin
                cnt_q   <= '1;
            end
        end else if ((state_q == PH_B_HIGH) & high_end & ~arb_bit) begin
            shift_q <= {shift_q[BYTE_W_L-1:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
            if (cnt_q == i2c_host_pkg::LAST_BIT) begin
                rxd_q  <= shift_q[BYTE_W_L-1:0];
                rxak_q <= sda_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky status, set wins over a write-one clear
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arb_lost_q <= 1'b0;
        end else if (set_arb) begin
            arb_lost_q <= 1'b1;
        end else if (acc_wr & (paddr == i2c_host_pkg::ADDR_STAT)
                     & pwdata[i2c_host_pkg::STAT_ARB_LOST]) begin
            arb_lost_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else if (set_done) begin
            done_q <= 1'b1;
        end else if (acc_wr & (paddr == i2c_host_pkg::ADDR_STAT)
                     & pwdata[i2c_host_pkg::STAT_DONE]) begin
            done_q <= 1'b0;
        end
    end

endmodule : i2c_host

// ==== bench/i2c_host_checker.sv ====
// Concurrent checks on the two-wire host's APB and bus-line ports.
`timescale 1ns/1ps
module i2c_host_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Bus lines
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    logic [7:0] hi_cnt_q;
    logic       acc;
    logic       mapped;

    assign acc    = psel && penable;
    assign mapped = paddr inside {i2c_host_pkg::ADDR_CMD, i2c_host_pkg::ADDR_TXD,
                                  i2c_host_pkg::ADDR_RXD, i2c_host_pkg::ADDR_STAT};

    // Cycles SCL has been high, saturating so idle bus reads as long enough
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) hi_cnt_q <= 8'h00;
        else if (!scl_in) hi_cnt_q <= 8'h00;
        else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_zero_wait: assert property (acc |-> pready) else $error("access without ready");
    a_unmapped_error: assert property (acc && !mapped && !pwrite |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
    a_open_drain_low: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_start_free_bus: assert property ($rose(sda_oe) && scl_in |->
        $past(sda_in) && hi_cnt_q >= i2c_host_pkg::T_SU_CYC) else $error("bad start");
    a_stop_setup: assert property ($fell(sda_oe) && scl_in |->
        hi_cnt_q >= i2c_host_pkg::T_SU_CYC) else $error("stop setup too short");
    a_high_time: assert property ($rose(scl_oe) && $past(scl_in) |->
        hi_cnt_q >= i2c_host_pkg::T_HIGH_CYC) else $error("clock high too short");
    a_reset_released: assert property ($rose(rst_b) |-> !scl_oe && !sda_oe)
        else $error("lines held after reset");

    c_start: cover property ($rose(sda_oe) && scl_in);
    c_stop: cover property ($fell(sda_oe) && scl_in);
    c_unmapped: cover property (acc && pslverr);
    c_stretch: cover property ((!scl_oe && !scl_in) [*8]);
endmodule : i2c_host_checker

bind i2c_host i2c_host_checker i2c_host_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ==== bench/i2c_dev_model.sv ====
// Behavioural slave device: one data byte, written by the host and echoed on reads.
`timescale 1ns/1ps
module i2c_dev_model #(
    parameter logic [6:0] OWN_ADDR   = 7'h50,
    parameter int         STRETCH_NS = 8000
) (
    // Bus lines, resolved
    input  wire logic scl,
    input  wire logic sda,
    // Test control
    input  wire logic stretch,
    // Open-drain pulls, high holds the line low
    output logic      scl_pull,
    output logic      sda_pull
);
    logic [7:0] byte_data_reg;
    logic [7:0] shift_q;
    logic       act;
    logic       rd;
    logic       addr_ph;
    int         cnt;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        act = 1'b0;
        rd = 1'b0;
        byte_data_reg = 8'h00;
    end
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        addr_ph = 1'b1;
        cnt = 0;
    end
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sda_pull = 1'b0;
    end
    always @(posedge scl) if (act) begin
        cnt++;
        if (cnt <= 8) shift_q = {shift_q[6:0], sda};
        else if (rd && !addr_ph && sda) act = 1'b0;
    end
    always @(negedge scl) if (act) begin
        if (cnt == 8) begin
            if (addr_ph) begin
                act = (shift_q[7:1] == OWN_ADDR);
                rd = shift_q[0];
            end else if (!rd) byte_data_reg = shift_q;
            sda_pull = act && !(rd && !addr_ph);
        end else if (cnt == 9) begin
            cnt = 0;
            addr_ph = 1'b0;
            sda_pull = 1'b0;
        end
        if (rd && !addr_ph && cnt < 8) sda_pull = !byte_data_reg[7 - cnt];
        // Slow answer: hold SCL low past the host's own low time
        if (stretch && cnt == 0) begin
            scl_pull = 1'b1;
            #(STRETCH_NS) scl_pull = 1'b0;
        end
    end
endmodule : i2c_dev_model

// ==== bench/i2c_host_tb.sv ====
// Self-checking bench: APB command sequences against a slave model.
`timescale 1ns/1ps
module i2c_host_tb;
    // ----
    // Signals
    // ----
    localparam logic [31:0] DN = 32'h1 << i2c_host_pkg::STAT_DONE;
    localparam logic [31:0] BB = 32'h1 << i2c_host_pkg::STAT_BUS_BUSY;
    localparam logic [31:0] AK = 32'h1 << i2c_host_pkg::STAT_RXAK;
    localparam logic [31:0] AL = 32'h1 << i2c_host_pkg::STAT_ARB_LOST;
    localparam logic [31:0] ST = 32'h1 << i2c_host_pkg::CMD_START;
    localparam logic [31:0] SP = 32'h1 << i2c_host_pkg::CMD_STOP;
    localparam logic [31:0] WR = 32'h1 << i2c_host_pkg::CMD_WRITE;
    localparam logic [31:0] RD = 32'h1 << i2c_host_pkg::CMD_READ;
    localparam logic [31:0] NK = 32'h1 << i2c_host_pkg::CMD_NACK;
    logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err_q;
    logic        scl_oe, sda_oe, scl_out, sda_out, dev_scl, dev_sda, x_sda, stretch;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q, st_q;
    int          bad_count, n_compared, cyc;
    wire         scl = !(scl_oe | dev_scl);
    wire         sda = !(sda_oe | dev_sda | x_sda);

    i2c_host i2c_host_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe));
    i2c_dev_model i2c_dev_model_inst (.scl(scl), .sda(sda), .stretch(stretch),
        .scl_pull(dev_scl), .sda_pull(dev_sda));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard: the whole sequence needs well under half of this
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One command; poll until idle, keep status, clear done
    task automatic cmd(input logic [7:0] txd, input logic [31:0] bits);
        apb(1'b1, i2c_host_pkg::ADDR_TXD, {24'h0, txd});
        apb(1'b1, i2c_host_pkg::ADDR_CMD, bits);
        rd_q = 32'h1;
        while (rd_q[i2c_host_pkg::STAT_BUSY] !== 1'b0) apb(1'b0, i2c_host_pkg::ADDR_STAT, 32'h0);
        st_q = rd_q;
        apb(1'b1, i2c_host_pkg::ADDR_STAT, DN);
    endtask : cmd

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results

    initial begin
        {rst_b, psel, penable, pwrite, x_sda, stretch} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {bad_count, n_compared, cyc} = '0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(1'b0, i2c_host_pkg::ADDR_STAT, 32'h0);
        check(rd_q, AK);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err_q}, 32'h1);
        cmd(8'hA0, ST | WR);
        check(st_q, DN | BB);
        cmd(8'h5A, WR);
        check(st_q, DN | BB);
        cmd(8'h00, SP);
        check(st_q, DN);
        cmd(8'hA2, ST | WR | SP);
        check(st_q, DN | AK);
        stretch <= 1'b1;
        cmd(8'hA0, ST | WR);
        check(st_q, DN | BB);
        cmd(8'hA1, ST | WR);
        check(st_q, DN | BB);
        cmd(8'h00, RD | NK);
        check(st_q, DN | BB | AK);
        apb(1'b0, i2c_host_pkg::ADDR_RXD, 32'h0);
        check(rd_q, 32'h5A);
        cmd(8'h00, SP);
        check(st_q, DN | AK);
        x_sda <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(1'b0, i2c_host_pkg::ADDR_STAT, 32'h0);
        check(rd_q, BB | AK);
        cmd(8'hA0, ST | WR);
        check(st_q, BB | AL | AK);
        x_sda <= 1'b0;
        repeat (4) @(posedge core_clk);
        apb(1'b0, i2c_host_pkg::ADDR_STAT, 32'h0);
        check(rd_q, AL | AK);
        apb(1'b1, i2c_host_pkg::ADDR_STAT, AL);
        apb(1'b0, i2c_host_pkg::ADDR_STAT, 32'h0);
        check(rd_q, AK);
        results();
    end
endmodule : i2c_host_tb
